// file: core/tap_consts.vh
/*
 Constants for the boundary scan test port: instruction codes, register
 lengths, controller state codes and the reset figures.
 Assumes it is included by bare name from the design files.
*/
// Function
// - Port follows the standard boundary-scan controller and mandatory instructions.
// - Inputs sampled on test clock rise, serial output and its enable updated on its fall.
// - Mode select steers the controller; open pin reads high.
// - Serial input feeds the MSB of the selected register; pulled up.
// - Serial output shows selected register LSB, changes on falling edges.
// - Five rises with mode select high reach reset from any state.
// - Test port reset never disturbs memory operation.
// - Power-up reset leaves serial output high impedance, memory undisturbed.
// - Current instruction selects exactly one data register.
// - Instruction register is three bits, loaded serially in the path.
// - Instruction register holds the identify code after power-up and reset.
// - Capture-IR loads the two low instruction bits with 01.
// - One-bit bypass register placed in path by the bypass instruction.
// - Bypass register clears low at Capture-DR.
// - Boundary register has one cell per package pin, spares included.
// - Capture-DR snapshots the pin ring; Shift-DR shifts boundary register.
// - Pin capture works under external-test, sample/preload and sample-high-Z.
// - Identify register is 32 bits, loaded with a fixed code.
// - New instruction takes effect only at Update-IR.
// - Sample-high-Z selects boundary register and floats read outputs.
// - Boundary cell 108 enables read outputs under external test; presets high.
`ifndef TAP_CONSTS_VH
`define TAP_CONSTS_VH

// ==========================================
// Instruction register
`define IR_LEN 3
`define IR_CAPTURE 3'h1
`define INS_EXTEST 3'h0
`define INS_IDCODE 3'h1
`define INS_SAMPLE_Z 3'h2
`define INS_SAMPLE 3'h4
`define INS_BYPASS 3'h7

// ==========================================
// Data registers
`define ID_LEN 32
`define BSR_LEN 109
`define BSR_OE_CELL 108
`define RESET_RISES 5

// ==========================================
// Controller states
`define ST_RESET 4'h0
`define ST_IDLE 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SH_DR 4'h4
`define ST_EX1_DR 4'h5
`define ST_PAU_DR 4'h6
`define ST_EX2_DR 4'h7
`define ST_UPD_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'ha
`define ST_SH_IR 4'hb
`define ST_EX1_IR 4'hc
`define ST_PAU_IR 4'hd
`define ST_EX2_IR 4'he
`define ST_UPD_IR 4'hf

`endif

// file: core/tap_fsm.v
/*
 Sixteen-state test port controller, advanced by a one-cycle enable that
 marks each rising edge of the test clock.
 Assumes the mode select level is already synchronised to sys_clk.
*/
`timescale 1ns/1ps
`include "tap_consts.vh"

module tap_fsm (
	input wire sys_clk,
	input wire reset,
	input wire rise_en,
	input wire tms,
	output reg [3:0] state_ff
);

	reg [3:0] nxt_state;

	// ==========================================
	// Next state from mode select level
	always @* begin
		case (state_ff)
		`ST_RESET: nxt_state = tms ? `ST_RESET : `ST_IDLE;
		`ST_IDLE: nxt_state = tms ? `ST_SEL_DR : `ST_IDLE;
		`ST_SEL_DR: nxt_state = tms ? `ST_SEL_IR : `ST_CAP_DR;
		`ST_CAP_DR: nxt_state = tms ? `ST_EX1_DR : `ST_SH_DR;
		`ST_SH_DR: nxt_state = tms ? `ST_EX1_DR : `ST_SH_DR;
		`ST_EX1_DR: nxt_state = tms ? `ST_UPD_DR : `ST_PAU_DR;
		`ST_PAU_DR: nxt_state = tms ? `ST_EX2_DR : `ST_PAU_DR;
		`ST_EX2_DR: nxt_state = tms ? `ST_UPD_DR : `ST_SH_DR;
		`ST_UPD_DR: nxt_state = tms ? `ST_SEL_DR : `ST_IDLE;
		`ST_SEL_IR: nxt_state = tms ? `ST_RESET : `ST_CAP_IR;
		`ST_CAP_IR: nxt_state = tms ? `ST_EX1_IR : `ST_SH_IR;
		`ST_SH_IR: nxt_state = tms ? `ST_EX1_IR : `ST_SH_IR;
		`ST_EX1_IR: nxt_state = tms ? `ST_UPD_IR : `ST_PAU_IR;
		`ST_PAU_IR: nxt_state = tms ? `ST_EX2_IR : `ST_PAU_IR;
		`ST_EX2_IR: nxt_state = tms ? `ST_UPD_IR : `ST_SH_IR;
		`ST_UPD_IR: nxt_state = tms ? `ST_SEL_DR : `ST_IDLE;
		default: nxt_state = `ST_RESET;
		endcase
	end

	// ==========================================
	// State register; moves only on test clock rises
	always @(posedge sys_clk) begin
		if (reset) begin
			state_ff <= `ST_RESET;
		end else if (rise_en) begin
			state_ff <= nxt_state;
		end
	end

endmodule

// file: core/tap_port.v
/*
 Boundary scan test access port: pin synchronisers, edge finder, controller,
 instruction, bypass, identify and boundary registers, serial output.
 Assumes the test clock is far slower than sys_clk (at least four sys_clk
 periods per phase) and that the pin ring arrives as a flat vector.
*/
`timescale 1ns/1ps
`include "tap_consts.vh"

module tap_port #(
	parameter BSR_LEN = `BSR_LEN,
	parameter [31:0] ID_CODE = 32'h00000001 // Arbitrary identification value
) (
	input wire sys_clk,
	input wire reset,
	input wire tck,
	input wire tms,
	input wire tdi,
	output reg tdo_ff,
	output reg tdo_oe_ff,
	input wire [BSR_LEN-1:0] pin_ring,
	output reg [BSR_LEN-1:0] bsr_out_ff,
	output wire extest_mode,
	output wire read_out_en
);

	// ==========================================
	// Pin synchronisers
	reg [1:0] tck_sync_ff;
	reg [1:0] tms_sync_ff;
	reg [1:0] tdi_sync_ff;
	reg tck_last_ff;
	wire rise_en;
	wire fall_en;
	wire [3:0] state;

	// Two flops each; open mode select and data read high after reset
	always @(posedge sys_clk) begin
		if (reset) begin
			tck_sync_ff <= 2'h0;
			tms_sync_ff <= 2'h3;
			tdi_sync_ff <= 2'h3;
			tck_last_ff <= 1'b0;
		end else begin
			tck_sync_ff <= {tck_sync_ff[0], tck};
			tms_sync_ff <= {tms_sync_ff[0], tms};
			tdi_sync_ff <= {tdi_sync_ff[0], tdi};
			tck_last_ff <= tck_sync_ff[1];
		end
	end

	// Edges of the test clock as one-cycle enables
	assign rise_en = tck_sync_ff[1] & ~tck_last_ff;
	assign fall_en = ~tck_sync_ff[1] & tck_last_ff;

	// ==========================================
	// Controller
	tap_fsm u_fsm (
		.sys_clk(sys_clk),
		.reset(reset),
		.rise_en(rise_en),
		.tms(tms_sync_ff[1]),
		.state_ff(state)
	);

	// ==========================================
	// Instruction decode
	reg [`IR_LEN-1:0] ir_shift_ff;
	reg [`IR_LEN-1:0] ir_ff;
	reg bypass_ff;
	reg [`ID_LEN-1:0] id_ff;
	reg [BSR_LEN-1:0] bsr_ff;

	// One data register per instruction; reserved codes fall to bypass
	function [1:0] dr_sel;
		input [`IR_LEN-1:0] ins;
		begin
			case (ins)
			`INS_IDCODE: dr_sel = 2'h1;
			`INS_EXTEST: dr_sel = 2'h2;
			`INS_SAMPLE: dr_sel = 2'h2;
			`INS_SAMPLE_Z: dr_sel = 2'h2;
			default: dr_sel = 2'h0;
			endcase
		end
	endfunction

	wire [1:0] sel = dr_sel(ir_ff);
	wire in_ctrl_reset = (state == `ST_RESET);

	// ==========================================
	// Instruction register
	// Forced while in reset state, so the identify code does not wait a rise
	always @(posedge sys_clk) begin
		if (reset) begin
			ir_shift_ff <= `INS_IDCODE;
			ir_ff <= `INS_IDCODE;
		end else if (in_ctrl_reset) begin
			ir_ff <= `INS_IDCODE;
		end else if (rise_en) begin
			if (state == `ST_CAP_IR) begin
				ir_shift_ff <= `IR_CAPTURE;
			end else if (state == `ST_SH_IR) begin
				ir_shift_ff <= {tdi_sync_ff[1], ir_shift_ff[`IR_LEN-1:1]};
			end else if (state == `ST_UPD_IR) begin
				ir_ff <= ir_shift_ff;
			end
		end
	end

	// ==========================================
	// Data registers: capture, then shift from MSB towards LSB
	always @(posedge sys_clk) begin
		if (reset) begin
			bypass_ff <= 1'b0;
			id_ff <= {`ID_LEN{1'b0}};
			bsr_ff <= {BSR_LEN{1'b0}};
		end else if (rise_en) begin
			if (state == `ST_CAP_DR) begin
				bypass_ff <= 1'b0;
				if (sel == 2'h1) begin
					id_ff <= ID_CODE;
				end
				if (sel == 2'h2) begin
					bsr_ff <= pin_ring;
				end
			end else if (state == `ST_SH_DR) begin
				if (sel == 2'h0) begin
					bypass_ff <= tdi_sync_ff[1];
				end
				if (sel == 2'h1) begin
					id_ff <= {tdi_sync_ff[1], id_ff[`ID_LEN-1:1]};
				end
				if (sel == 2'h2) begin
					bsr_ff <= {tdi_sync_ff[1], bsr_ff[BSR_LEN-1:1]};
				end
			end
		end
	end

	// ==========================================
	// Boundary update latches; output-enable cell presets high
	always @(posedge sys_clk) begin
		if (reset) begin
			bsr_out_ff <= {BSR_LEN{1'b0}};
			bsr_out_ff[`BSR_OE_CELL] <= 1'b1;
		end else if (in_ctrl_reset) begin
			bsr_out_ff[`BSR_OE_CELL] <= 1'b1;
		end else if (rise_en && state == `ST_UPD_DR && sel == 2'h2) begin
			bsr_out_ff <= bsr_ff;
		end
	end

	// Read-bus enable: only the test instructions touch it, memory untouched
	assign extest_mode = (ir_ff == `INS_EXTEST);
	assign read_out_en = (ir_ff == `INS_SAMPLE_Z) ? 1'b0 :
		extest_mode ? bsr_out_ff[`BSR_OE_CELL] : 1'b1;

	// ==========================================
	// Serial output, LSB of the path, moved on test clock falls
	reg nxt_tdo;
	always @* begin
		if (state == `ST_SH_IR) begin
			nxt_tdo = ir_shift_ff[0];
		end else begin
			case (sel)
			2'h1: nxt_tdo = id_ff[0];
			2'h2: nxt_tdo = bsr_ff[0];
			default: nxt_tdo = bypass_ff;
			endcase
		end
	end

	// Enable tracks shift states so the pin floats elsewhere
	always @(posedge sys_clk) begin
		if (reset) begin
			tdo_ff <= 1'b0;
			tdo_oe_ff <= 1'b0;
		end else if (fall_en) begin
			tdo_ff <= nxt_tdo;
			tdo_oe_ff <= (state == `ST_SH_IR) || (state == `ST_SH_DR);
		end
	end

endmodule

// file: verif/tap_port_sva.sv
/*
 Checker for the test port outputs.
 Assumes the test clock phases last at least four sys_clk periods.
*/
`timescale 1ns/1ps
module tap_port_sva #(
	parameter BSR_LEN = 109
) (
	input logic sys_clk,
	input logic reset,
	input logic tck,
	input logic tms,
	input logic tdi,
	input logic tdo_ff,
	input logic tdo_oe_ff,
	input logic [BSR_LEN-1:0] pin_ring,
	input logic [BSR_LEN-1:0] bsr_out_ff,
	input logic extest_mode,
	input logic read_out_en
);
	logic tck_q;
	logic [2:0] hi_cnt;
	// ==========
	// Rises seen with mode select high; saturates so it never wraps
	always @(posedge sys_clk) begin
		tck_q <= tck;
		if (reset || (tck && !tck_q && !tms))
			hi_cnt <= 3'h0;
		else if (tck && !tck_q && hi_cnt != 3'h7)
			hi_cnt <= hi_cnt + 3'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	rst_idle_a: assert property ($fell(reset) |-> !tdo_oe_ff && !extest_mode && read_out_en)
		else $error("bad state after reset");
	rst_preset_a: assert property ($fell(reset) |-> bsr_out_ff == {1'b1, {(BSR_LEN-1){1'b0}}})
		else $error("output enable cell not preset");
	tdo_fall_a: assert property ($changed(tdo_ff) |-> !$past(tck) && !$past(tck, 2))
		else $error("serial out moved off a falling edge");
	oe_fall_a: assert property ($changed(tdo_oe_ff) |-> !$past(tck) && !$past(tck, 2))
		else $error("serial enable moved off a falling edge");
	upd_rise_a: assert property ($changed(bsr_out_ff) |-> $past(tck) && $past(tck, 2))
		else $error("boundary latches moved off a rising edge");
	ins_rise_a: assert property ($changed(extest_mode) |-> $past(tck) && $past(tck, 2))
		else $error("instruction moved off a rising edge");
	extest_oe_a: assert property (extest_mode |-> read_out_en == bsr_out_ff[BSR_LEN-1])
		else $error("read enable not following cell");
	tap_rst_a: assert property (hi_cnt == 3'h5 |-> ##4 (!extest_mode && read_out_en))
		else $error("five high rises did not reset");
endmodule

bind tap_port tap_port_sva #(.BSR_LEN(BSR_LEN)) chk_u (.sys_clk(sys_clk), .reset(reset),
	.tck(tck), .tms(tms), .tdi(tdi), .tdo_ff(tdo_ff), .tdo_oe_ff(tdo_oe_ff),
	.pin_ring(pin_ring), .bsr_out_ff(bsr_out_ff), .extest_mode(extest_mode),
	.read_out_en(read_out_en));

// file: verif/jtag_ctrl_model.sv
/*
 Model of the external scan controller.
 Assumes sys_clk runs free and each step is entered just after a sys_clk
 edge; the test clock stands low between steps.
*/
`timescale 1ns/1ps
module jtag_ctrl_model (
	input wire sys_clk,
	input wire tdo_ff,
	input wire tdo_oe_ff,
	output logic tck,
	output logic tms,
	output logic tdi
);
	// ==========
	// Idle: clock low, pulled-up lines high
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// One 400 ns test clock, four cycles each phase; lines change as it falls
	task automatic step(input logic m, input logic d, output logic q);
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge sys_clk);
		q = tdo_oe_ff ? tdo_ff : 1'bz;
		tck <= 1'b1;
		repeat (4) @(posedge sys_clk);
		tck <= 1'b0;
	endtask
	// Run-Idle, one scan, back to Run-Idle
	task automatic scan(input bit ir, input int n, input logic [108:0] din,
		output logic [108:0] dout);
		logic q;
		dout = '0;
		if (ir) step(1'b1, 1'b1, q);
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask
	// Port reset by mode select held high
	task automatic tap_reset();
		logic q;
		repeat (5) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask
endmodule

// file: verif/test_jtag_boundary_scan_tap.sv
/*
 Testbench for the test port with the controller model.
 Assumes tap_consts.vh is on the include path.
*/
`timescale 1ns/1ps
`include "tap_consts.vh"
module test_jtag_boundary_scan_tap;
	localparam logic [31:0] ID = 32'h0a5c3e71; // Arbitrary value
	logic sys_clk, reset;
	logic [108:0] pin_ring, got;
	wire tck, tms, tdi, tdo_ff, tdo_oe_ff, extest_mode, read_out_en;
	wire [108:0] bsr_out_ff;
	int n_mismatch = 0, n_tests = 0, cycles = 0;
	tap_port #(.BSR_LEN(`BSR_LEN), .ID_CODE(ID)) dut_u (.sys_clk(sys_clk), .reset(reset),
		.tck(tck), .tms(tms), .tdi(tdi), .tdo_ff(tdo_ff), .tdo_oe_ff(tdo_oe_ff),
		.pin_ring(pin_ring), .bsr_out_ff(bsr_out_ff), .extest_mode(extest_mode),
		.read_out_en(read_out_en));
	jtag_ctrl_model ctl_u (.sys_clk(sys_clk), .tdo_ff(tdo_ff), .tdo_oe_ff(tdo_oe_ff),
		.tck(tck), .tms(tms), .tdi(tdi));
	// ==========
	task automatic chk(input logic [108:0] exp, input logic [108:0] act);
		n_tests++;
		if (exp !== act) begin
			n_mismatch++;
			$display("Error at %0t: expected %h, got %h", $time, exp, act);
		end
	endtask
	task automatic test_done();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Identify code read straight after a reset
	task automatic t_idcode();
		ctl_u.scan(1'b0, 32, '0, got);
		chk(109'(ID), got);
	endtask
	// Capture pattern, then a bypass path of one cleared bit
	task automatic t_bypass();
		ctl_u.scan(1'b1, 3, 109'(`INS_BYPASS), got);
		chk(109'(`IR_CAPTURE), got);
		ctl_u.scan(1'b0, 8, 109'hb4, got);
		chk(109'h68, got);
		chk('0, 109'(tdo_oe_ff));
	endtask
	// Ring capture and preload under each ring instruction
	task automatic t_ring();
		logic [2:0] code [3] = '{`INS_SAMPLE, `INS_EXTEST, `INS_SAMPLE_Z};
		logic [108:0] din;
		for (int k = 0; k < 3; k++) begin
			@(posedge sys_clk) pin_ring <= {2'(k), 107'h5a3_c1e7_0f96_d2b4_8e71};
			din = {1'b0, 2'(k), 106'hc3_96e1_7d2b_5a48};
			ctl_u.scan(1'b1, 3, 109'(code[k]), got);
			chk(109'(k == 1), 109'(extest_mode));
			chk(109'(k == 0), 109'(read_out_en));
			ctl_u.scan(1'b0, 109, din, got);
			chk(pin_ring, got);
			chk(din, bsr_out_ff);
		end
	endtask
	// ==========
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// Hang guard, well above the run length
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			test_done();
		end
	end
	initial begin
		reset = 1'b1;
		pin_ring = '0;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		chk(109'h1 << 108, bsr_out_ff);
		ctl_u.step(1'b0, 1'b1, got[0]);
		t_idcode();
		t_bypass();
		t_ring();
		ctl_u.tap_reset();
		chk(109'h1, 109'(read_out_en));
		t_idcode();
		test_done();
	end
endmodule
